// ### verilog/eocr_regs.sv
// Encoder output configuration register bank with pin source decode and payload serialiser
//
// What this block does
// R01 - Copy generation data goes out only while the enable bit is set; reset clears it.
// R02 - Twenty-bit payload across three registers, each byte sent LSB first after run-in.
// R03 - Software places the CRC bits in the payload byte MSBs; sent unchanged.
// R04 - Software writes zero into every unused bit position.
// R05 - Green luma select set (reset) puts luminance on the green pin unless green composite select is set.
// R06 - Green composite select set puts composite video on the green pin.
// R07 - Blue composite select set (reset) puts composite on blue, else component blue.
// R08 - Red chroma select set (reset) puts S-video chroma on red, else component red.
// R09 - Red composite select set forces composite on red regardless of chroma select.
// R10 - Encoder bypass feeds the DACs with RGB after cursor insertion.
// R11 - Clock-out select set (reset) drives half crystal clock, else teletext request.
// R12 - Vertical upscale enables upscaling and makes the vertical filter unavailable.
// R13 - Filter field: 00 none, 01 before scaling, 10 after scaling, 11 reserved.
// R14 - Software keeps line skip at zero when the filter sits after scaling.
// R15 - Cursor zoom doubles the cursor in both directions.
// R16 - Input swing bit: 0 means 16..235, 1 means 0..255.
// R17 - Horizontal interpolation bit enables the filter during horizontal upscaling.
// R18 - Every field reads back what was written and takes its default on reset.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "eocr_cfg.svh"
module eocr_regs
  import eocr_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire eocr_bus_req_t bus_req,
  output logic [7:0]         rd_data_ff,
  input  wire logic          cg_runin_done,
  input  wire logic          cg_bit_tick,
  input  wire logic          teletext_request,
  input  wire logic          half_crystal_clk,
  output logic               teletext_req_or_clock_pin_ff,
  output eocr_dac_src_t      green_dac_src_ff,
  output eocr_dac_src_t      blue_dac_src_ff,
  output eocr_dac_src_t      red_dac_src_ff,
  output logic               encoder_bypass_ff,
  output logic               copy_gen_active_ff,
  output logic               copy_gen_bit_ff,
  output logic               copy_gen_bit_valid_ff,
  output logic               vertical_upscale_en_ff,
  output eocr_vfil_t         vertical_filter_place_ff,
  output logic [1:0]         cursor_zoom_factor_ff,
  output logic [7:0]         input_swing_min_ff,
  output logic [7:0]         input_swing_max_ff,
  output logic               horizontal_interp_en_ff
);

  // Stored register bytes
  logic [7:0]           cg_low_ff;
  logic [7:0]           cg_mid_ff;
  logic [7:0]           cg_high_ff;
  logic [7:0]           pin_sel_ff;
  logic [7:0]           scaler_ff;

  // Write strobes per register
  logic                 wr_cg_low;
  logic                 wr_cg_mid;
  logic                 wr_cg_high;
  logic                 wr_pin_sel;
  logic                 wr_scaler;

  // Named fields
  logic                 copy_gen_enable;
  logic [19:0]          copy_gen_payload;
  logic                 green_pin_luma_sel;
  logic                 green_pin_composite_sel;
  logic                 blue_pin_composite_sel;
  logic                 red_pin_chroma_sel;
  logic                 red_pin_composite_sel;
  logic                 encoder_bypass;
  logic                 half_crystal_clock_out_sel;
  logic                 vertical_upscale_en;
  logic [1:0]           vertical_filter_place;
  logic                 cursor_zoom;
  logic                 input_swing_sel;
  logic                 horizontal_interp_en;

  // Read data selection
  logic [7:0]           nxt_rd_data;

  // Clock pin synchroniser
  logic                 half_clk_meta_ff;
  logic                 half_clk_sync_ff;

  // Payload serialiser
  eocr_cg_state_t       cg_state_ff;
  logic [19:0]          cg_shadow_ff;
  logic [4:0]           cg_idx_ff;

  // Address decode of write strobes
  assign wr_cg_low  = bus_req.wr && (bus_req.addr == `EOCR_ADDR_CG_LOW);
  assign wr_cg_mid  = bus_req.wr && (bus_req.addr == `EOCR_ADDR_CG_MID);
  assign wr_cg_high = bus_req.wr && (bus_req.addr == `EOCR_ADDR_CG_HIGH);
  assign wr_pin_sel = bus_req.wr && (bus_req.addr == `EOCR_ADDR_PIN_SEL);
  assign wr_scaler  = bus_req.wr && (bus_req.addr == `EOCR_ADDR_SCALER);

  // Payload low byte
  eocr_byte_reg #(
    .RESET_VAL (`EOCR_RST_CG_LOW)
  ) u_cg_low (
    .mclk    (mclk),
    .srst    (srst),
    .wr_en   (wr_cg_low),
    .wr_data (bus_req.wdata),
    .q_ff    (cg_low_ff)
  );

  // Payload middle byte
  eocr_byte_reg #(
    .RESET_VAL (`EOCR_RST_CG_MID)
  ) u_cg_mid (
    .mclk    (mclk),
    .srst    (srst),
    .wr_en   (wr_cg_mid),
    .wr_data (bus_req.wdata),
    .q_ff    (cg_mid_ff)
  );

  // Enable bit and payload high nibble
  eocr_byte_reg #(
    .RESET_VAL (`EOCR_RST_CG_HIGH)
  ) u_cg_high (
    .mclk    (mclk),
    .srst    (srst),
    .wr_en   (wr_cg_high),
    .wr_data (bus_req.wdata),
    .q_ff    (cg_high_ff)
  );

  // Output pin select byte
  eocr_byte_reg #(
    .RESET_VAL (`EOCR_RST_PIN_SEL)
  ) u_pin_sel (
    .mclk    (mclk),
    .srst    (srst),
    .wr_en   (wr_pin_sel),
    .wr_data (bus_req.wdata),
    .q_ff    (pin_sel_ff)
  );

  // Scaler, cursor and input control byte
  eocr_byte_reg #(
    .RESET_VAL (`EOCR_RST_SCALER)
  ) u_scaler (
    .mclk    (mclk),
    .srst    (srst),
    .wr_en   (wr_scaler),
    .wr_data (bus_req.wdata),
    .q_ff    (scaler_ff)
  );

  // Field extraction; unused bits are stored but steer nothing
  assign copy_gen_enable            = cg_high_ff[`EOCR_CG_EN_BIT];
  assign copy_gen_payload           = {cg_high_ff[`EOCR_CG_HI_MSB:`EOCR_CG_HI_LSB], cg_mid_ff, cg_low_ff}; // R02
  assign green_pin_luma_sel         = pin_sel_ff[`EOCR_GREEN_LUMA_BIT];
  assign green_pin_composite_sel    = pin_sel_ff[`EOCR_GREEN_CVBS_BIT];
  assign blue_pin_composite_sel     = pin_sel_ff[`EOCR_BLUE_CVBS_BIT];
  assign red_pin_chroma_sel         = pin_sel_ff[`EOCR_RED_CHROMA_BIT];
  assign encoder_bypass             = pin_sel_ff[`EOCR_ENC_BYPASS_BIT];
  assign half_crystal_clock_out_sel = pin_sel_ff[`EOCR_CLK_OUT_BIT];
  assign red_pin_composite_sel      = pin_sel_ff[`EOCR_RED_CVBS_BIT];
  assign vertical_upscale_en        = scaler_ff[`EOCR_VUPSC_BIT];
  assign vertical_filter_place      = scaler_ff[`EOCR_VFIL_MSB:`EOCR_VFIL_LSB];
  assign cursor_zoom                = scaler_ff[`EOCR_CURSOR_ZOOM_BIT];
  assign input_swing_sel            = scaler_ff[`EOCR_INPUT_SWING_SEL_BIT];
  assign horizontal_interp_en       = scaler_ff[`EOCR_HORIZONTAL_INTERP_EN_BIT];

  // Read mux: full stored byte, zero for unmapped addresses
  always_comb begin
    nxt_rd_data = `EOCR_RD_IDLE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `EOCR_ADDR_CG_LOW:  nxt_rd_data = cg_low_ff;   // R18
        `EOCR_ADDR_CG_MID:  nxt_rd_data = cg_mid_ff;   // R18
        `EOCR_ADDR_CG_HIGH: nxt_rd_data = cg_high_ff;  // R18
        `EOCR_ADDR_PIN_SEL: nxt_rd_data = pin_sel_ff;  // R18
        `EOCR_ADDR_SCALER:  nxt_rd_data = scaler_ff;   // R18
        default:            nxt_rd_data = `EOCR_RD_IDLE;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data_ff <= `EOCR_RD_IDLE;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Green pin source; composite select outranks luma select
  always_ff @(posedge mclk) begin
    if (srst) begin
      green_dac_src_ff <= EOCR_DAC_LUMA;
    end else if (encoder_bypass) begin
      green_dac_src_ff <= EOCR_DAC_RGB_BYPASS;   // R10
    end else if (green_pin_composite_sel) begin
      green_dac_src_ff <= EOCR_DAC_COMPOSITE;    // R06
    end else if (green_pin_luma_sel) begin
      green_dac_src_ff <= EOCR_DAC_LUMA;         // R05
    end else begin
      green_dac_src_ff <= EOCR_DAC_COMPONENT;    // R05
    end
  end

  // Blue pin source
  always_ff @(posedge mclk) begin
    if (srst) begin
      blue_dac_src_ff <= EOCR_DAC_COMPOSITE;
    end else if (encoder_bypass) begin
      blue_dac_src_ff <= EOCR_DAC_RGB_BYPASS;    // R10
    end else if (blue_pin_composite_sel) begin
      blue_dac_src_ff <= EOCR_DAC_COMPOSITE;     // R07
    end else begin
      blue_dac_src_ff <= EOCR_DAC_COMPONENT;     // R07
    end
  end

  // Red pin source; composite overrides the chroma select
  always_ff @(posedge mclk) begin
    if (srst) begin
      red_dac_src_ff <= EOCR_DAC_CHROMA;
    end else if (encoder_bypass) begin
      red_dac_src_ff <= EOCR_DAC_RGB_BYPASS;     // R10
    end else if (red_pin_composite_sel) begin
      red_dac_src_ff <= EOCR_DAC_COMPOSITE;      // R09
    end else if (red_pin_chroma_sel) begin
      red_dac_src_ff <= EOCR_DAC_CHROMA;         // R08
    end else begin
      red_dac_src_ff <= EOCR_DAC_COMPONENT;      // R08
    end
  end

  // Encoder bypass flag for the datapath
  always_ff @(posedge mclk) begin
    if (srst) begin
      encoder_bypass_ff <= 1'b0;
    end else begin
      encoder_bypass_ff <= encoder_bypass;       // R10
    end
  end

  // Half crystal clock arrives from another domain; two stages before use
  always_ff @(posedge mclk) begin
    if (srst) begin
      half_clk_meta_ff <= 1'b0;
      half_clk_sync_ff <= 1'b0;
    end else begin
      half_clk_meta_ff <= half_crystal_clk;
      half_clk_sync_ff <= half_clk_meta_ff;
    end
  end

  // Dual-purpose pin: half clock or teletext request
  always_ff @(posedge mclk) begin
    if (srst) begin
      teletext_req_or_clock_pin_ff <= 1'b0;
    end else if (half_crystal_clock_out_sel) begin
      teletext_req_or_clock_pin_ff <= half_clk_sync_ff;  // R11
    end else begin
      teletext_req_or_clock_pin_ff <= teletext_request;  // R11
    end
  end

  // Vertical scaler mode and effective filter place
  always_ff @(posedge mclk) begin
    if (srst) begin
      vertical_upscale_en_ff   <= 1'b0;
      vertical_filter_place_ff <= EOCR_VFIL_NONE;
    end else begin
      vertical_upscale_en_ff <= vertical_upscale_en;     // R12
      if (vertical_upscale_en) begin
        vertical_filter_place_ff <= EOCR_VFIL_NONE;      // R12
      end else begin
        unique case (vertical_filter_place)
          2'h1:    vertical_filter_place_ff <= EOCR_VFIL_BEFORE;  // R13
          2'h2:    vertical_filter_place_ff <= EOCR_VFIL_AFTER;   // R13
          default: vertical_filter_place_ff <= EOCR_VFIL_NONE;    // R13
        endcase
      end
    end
  end

  // Cursor zoom, input swing and horizontal interpolation
  always_ff @(posedge mclk) begin
    if (srst) begin
      cursor_zoom_factor_ff   <= `EOCR_ZOOM_X1;
      input_swing_min_ff      <= `EOCR_SWING_NARROW_MIN;
      input_swing_max_ff      <= `EOCR_SWING_NARROW_MAX;
      horizontal_interp_en_ff <= 1'b0;
    end else begin
      cursor_zoom_factor_ff   <= cursor_zoom ? `EOCR_ZOOM_X2 : `EOCR_ZOOM_X1;                    // R15
      input_swing_min_ff      <= input_swing_sel ? `EOCR_SWING_FULL_MIN : `EOCR_SWING_NARROW_MIN; // R16
      input_swing_max_ff      <= input_swing_sel ? `EOCR_SWING_FULL_MAX : `EOCR_SWING_NARROW_MAX; // R16
      horizontal_interp_en_ff <= horizontal_interp_en;                                            // R17
    end
  end

  // Serialiser state: start after run-in only when enabled
  always_ff @(posedge mclk) begin
    if (srst) begin
      cg_state_ff <= EOCR_CG_IDLE;
    end else begin
      unique case (cg_state_ff)
        EOCR_CG_IDLE: begin
          if (cg_runin_done && copy_gen_enable) begin
            cg_state_ff <= EOCR_CG_SEND;                 // R01
          end
        end
        EOCR_CG_SEND: begin
          if (!copy_gen_enable) begin
            cg_state_ff <= EOCR_CG_IDLE;                 // R01
          end else if (cg_bit_tick && (cg_idx_ff == `EOCR_CG_LAST_IDX)) begin
            cg_state_ff <= EOCR_CG_IDLE;
          end
        end
      endcase
    end
  end

  // Payload snapshot and bit index; index order sends each byte LSB first
  always_ff @(posedge mclk) begin
    if (srst) begin
      cg_shadow_ff <= '0;
      cg_idx_ff    <= `EOCR_CG_IDX_ZERO;
    end else if (cg_state_ff == EOCR_CG_IDLE) begin
      if (cg_runin_done && copy_gen_enable) begin
        cg_shadow_ff <= copy_gen_payload;                // R03
        cg_idx_ff    <= `EOCR_CG_IDX_ZERO;               // R02
      end
    end else if (cg_bit_tick) begin
      cg_idx_ff <= cg_idx_ff + `EOCR_CG_IDX_ONE;         // R02
    end
  end

  // Serial bit and its valid flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      copy_gen_bit_ff       <= 1'b0;
      copy_gen_bit_valid_ff <= 1'b0;
      copy_gen_active_ff    <= 1'b0;
    end else begin
      copy_gen_active_ff <= copy_gen_enable;             // R01
      if ((cg_state_ff == EOCR_CG_SEND) && copy_gen_enable && cg_bit_tick) begin
        copy_gen_bit_ff       <= cg_shadow_ff[cg_idx_ff];  // R02
        copy_gen_bit_valid_ff <= 1'b1;
      end else begin
        copy_gen_bit_ff       <= 1'b0;
        copy_gen_bit_valid_ff <= 1'b0;
      end
    end
  end

endmodule

// ### verilog/eocr_cfg.svh
// Address map, reset values, field positions and constants of the encoder output config bank
`ifndef EOCR_CFG_SVH
`define EOCR_CFG_SVH

// Register addresses on the 8-bit register port
`define EOCR_ADDR_CG_LOW       8'h2A
`define EOCR_ADDR_CG_MID       8'h2B
`define EOCR_ADDR_CG_HIGH      8'h2C
`define EOCR_ADDR_PIN_SEL      8'h2D
`define EOCR_ADDR_SCALER       8'h37

// Reset values of the stored bytes
`define EOCR_RST_CG_LOW        8'h00
`define EOCR_RST_CG_MID        8'h00
`define EOCR_RST_CG_HIGH       8'h00
`define EOCR_RST_PIN_SEL       8'hB4
`define EOCR_RST_SCALER        8'h00

// Answer to an unmapped address and idle read data
`define EOCR_RD_IDLE           8'h00

// Copy generation high byte fields
`define EOCR_CG_EN_BIT         7
`define EOCR_CG_HI_MSB         3
`define EOCR_CG_HI_LSB         0

// Output pin select fields
`define EOCR_GREEN_LUMA_BIT    7
`define EOCR_GREEN_CVBS_BIT    6
`define EOCR_BLUE_CVBS_BIT     5
`define EOCR_RED_CHROMA_BIT    4
`define EOCR_ENC_BYPASS_BIT    3
`define EOCR_CLK_OUT_BIT       2
`define EOCR_RED_CVBS_BIT      1

// Scaler, cursor and input control fields
`define EOCR_VUPSC_BIT         6
`define EOCR_VFIL_MSB          5
`define EOCR_VFIL_LSB          4
`define EOCR_CURSOR_ZOOM_BIT         2
`define EOCR_INPUT_SWING_SEL_BIT         1
`define EOCR_HORIZONTAL_INTERP_EN_BIT          0

// Copy generation payload length and last bit index
`define EOCR_CG_BITS           20
`define EOCR_CG_LAST_IDX       5'h13
`define EOCR_CG_IDX_ZERO       5'h00
`define EOCR_CG_IDX_ONE        5'h01

// Expected input swing limits for 8-bit RGB
`define EOCR_SWING_NARROW_MIN  8'h10
`define EOCR_SWING_NARROW_MAX  8'hEB
`define EOCR_SWING_FULL_MIN    8'h00
`define EOCR_SWING_FULL_MAX    8'hFF

// Cursor magnification factors
`define EOCR_ZOOM_X1           2'h1
`define EOCR_ZOOM_X2           2'h2

`endif

// ### verilog/eocr_pkg.sv
// Types shared by the encoder output config bank
package eocr_pkg;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eocr_bus_req_t;

  // Signal carried by a DAC output pin
  typedef enum logic [2:0] {
    EOCR_DAC_COMPONENT,
    EOCR_DAC_LUMA,
    EOCR_DAC_CHROMA,
    EOCR_DAC_COMPOSITE,
    EOCR_DAC_RGB_BYPASS
  } eocr_dac_src_t;

  // Vertical interpolation filter placement
  typedef enum logic [1:0] {
    EOCR_VFIL_NONE,
    EOCR_VFIL_BEFORE,
    EOCR_VFIL_AFTER
  } eocr_vfil_t;

  // Copy generation serialiser state
  typedef enum logic {
    EOCR_CG_IDLE,
    EOCR_CG_SEND
  } eocr_cg_state_t;

endpackage

// ### verilog/eocr_byte_reg.sv
// One software-writable byte register with a reset value
`timescale 1ns/1ps
module eocr_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q_ff
);

  // Store on write, default on reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      q_ff <= RESET_VAL;
    end else if (wr_en) begin
      q_ff <= wr_data;
    end
  end

endmodule

// ### tb/eocr_regs_properties.sv
// Port checker for the encoder output config bank
`timescale 1ns/1ps
`include "eocr_cfg.svh"
module eocr_regs_chk
  import eocr_pkg::*;
(
  input wire logic          mclk,
  input wire logic          srst,
  input wire eocr_bus_req_t bus_req,
  input wire logic [7:0]    rd_data_ff,
  input wire logic          cg_runin_done,
  input wire logic          cg_bit_tick,
  input wire logic          teletext_request,
  input wire logic          half_crystal_clk,
  input wire logic          teletext_req_or_clock_pin_ff,
  input wire eocr_dac_src_t green_dac_src_ff,
  input wire eocr_dac_src_t blue_dac_src_ff,
  input wire eocr_dac_src_t red_dac_src_ff,
  input wire logic          encoder_bypass_ff,
  input wire logic          copy_gen_active_ff,
  input wire logic          copy_gen_bit_ff,
  input wire logic          copy_gen_bit_valid_ff,
  input wire logic          vertical_upscale_en_ff,
  input wire eocr_vfil_t    vertical_filter_place_ff,
  input wire logic [1:0]    cursor_zoom_factor_ff,
  input wire logic [7:0]    input_swing_min_ff,
  input wire logic [7:0]    input_swing_max_ff,
  input wire logic          horizontal_interp_en_ff
);
  logic [7:0] cgh_m, pin_m, scl_m, cgl_m, cgm_m, rd_exp;
  logic       srst_hold_ff;
  default clocking @(posedge mclk); endclocking
  // Off also at the edge that releases reset
  default disable iff (srst || srst_hold_ff);
  // Shadow of the stored bytes, rebuilt from port writes
  always_ff @(posedge mclk) begin
    srst_hold_ff <= srst;
    if (srst) begin
      {cgl_m, cgm_m, cgh_m} <= {`EOCR_RST_CG_LOW, `EOCR_RST_CG_MID, `EOCR_RST_CG_HIGH};
      {pin_m, scl_m} <= {`EOCR_RST_PIN_SEL, `EOCR_RST_SCALER};
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `EOCR_ADDR_CG_LOW:  cgl_m <= bus_req.wdata;
        `EOCR_ADDR_CG_MID:  cgm_m <= bus_req.wdata;
        `EOCR_ADDR_CG_HIGH: cgh_m <= bus_req.wdata;
        `EOCR_ADDR_PIN_SEL: pin_m <= bus_req.wdata;
        `EOCR_ADDR_SCALER:  scl_m <= bus_req.wdata;
        default: ;
      endcase
    end
  end
  // Answer expected for a read at the present address
  always_comb begin
    case (bus_req.addr)
      `EOCR_ADDR_CG_LOW:  rd_exp = cgl_m;
      `EOCR_ADDR_CG_MID:  rd_exp = cgm_m;
      `EOCR_ADDR_CG_HIGH: rd_exp = cgh_m;
      `EOCR_ADDR_PIN_SEL: rd_exp = pin_m;
      `EOCR_ADDR_SCALER:  rd_exp = scl_m;
      default:            rd_exp = `EOCR_RD_IDLE;
    endcase
  end
  a_read_answer: assert property ($past(bus_req.rd) |-> rd_data_ff == $past(rd_exp))
    else $error("read data differs from stored byte");
  a_read_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data_ff == `EOCR_RD_IDLE)
    else $error("read data not idle outside read answer");
  a_green_src: assert property (green_dac_src_ff == ($past(pin_m[3]) ? EOCR_DAC_RGB_BYPASS :
    $past(pin_m[6]) ? EOCR_DAC_COMPOSITE : $past(pin_m[7]) ? EOCR_DAC_LUMA : EOCR_DAC_COMPONENT))
    else $error("green pin source wrong");
  a_blue_src: assert property (blue_dac_src_ff == ($past(pin_m[3]) ? EOCR_DAC_RGB_BYPASS :
    $past(pin_m[5]) ? EOCR_DAC_COMPOSITE : EOCR_DAC_COMPONENT)) else $error("blue pin source wrong");
  a_red_src: assert property (red_dac_src_ff == ($past(pin_m[3]) ? EOCR_DAC_RGB_BYPASS :
    $past(pin_m[1]) ? EOCR_DAC_COMPOSITE : $past(pin_m[4]) ? EOCR_DAC_CHROMA : EOCR_DAC_COMPONENT))
    else $error("red pin source wrong");
  a_bypass_flag: assert property (encoder_bypass_ff == $past(pin_m[3]))
    else $error("bypass flag wrong");
  a_pin_teletext: assert property (!$past(pin_m[2]) |-> teletext_req_or_clock_pin_ff == $past(teletext_request))
    else $error("dual pin does not follow teletext request");
  a_filter_place: assert property (vertical_filter_place_ff ==
    (($past(scl_m[6]) || $past(scl_m[5:4]) == 2'h3) ? EOCR_VFIL_NONE : eocr_vfil_t'($past(scl_m[5:4]))))
    else $error("filter placement wrong");
  a_scaler_misc: assert property ({vertical_upscale_en_ff, horizontal_interp_en_ff} ==
    {$past(scl_m[6]), $past(scl_m[0])} && cursor_zoom_factor_ff == ($past(scl_m[2]) ? `EOCR_ZOOM_X2 : `EOCR_ZOOM_X1))
    else $error("scaler or cursor decode wrong");
  a_swing_range: assert property ({input_swing_min_ff, input_swing_max_ff} ==
    ($past(scl_m[1]) ? 16'h00FF : 16'h10EB)) else $error("input swing limits wrong");
  a_cg_active: assert property (copy_gen_active_ff == $past(cgh_m[7])) else $error("payload enable wrong");
  a_cg_quiet: assert property (!$past(cgh_m[7]) |-> !copy_gen_bit_valid_ff) else $error("payload sent while off");
  a_cg_tick_pace: assert property (copy_gen_bit_valid_ff |-> $past(cg_bit_tick))
    else $error("payload bit without tick");
  c_readback: cover property ($past(bus_req.rd) && rd_data_ff != 8'h00);
  c_bypass: cover property (encoder_bypass_ff);
  c_cg_bit: cover property (copy_gen_bit_valid_ff && copy_gen_bit_ff);
endmodule
bind eocr_regs eocr_regs_chk u_eocr_regs_chk (.mclk(mclk), .srst(srst), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
  .cg_runin_done(cg_runin_done), .cg_bit_tick(cg_bit_tick), .teletext_request(teletext_request),
  .half_crystal_clk(half_crystal_clk), .teletext_req_or_clock_pin_ff(teletext_req_or_clock_pin_ff),
  .green_dac_src_ff(green_dac_src_ff), .blue_dac_src_ff(blue_dac_src_ff), .red_dac_src_ff(red_dac_src_ff),
  .encoder_bypass_ff(encoder_bypass_ff), .copy_gen_active_ff(copy_gen_active_ff),
  .copy_gen_bit_ff(copy_gen_bit_ff), .copy_gen_bit_valid_ff(copy_gen_bit_valid_ff),
  .vertical_upscale_en_ff(vertical_upscale_en_ff), .vertical_filter_place_ff(vertical_filter_place_ff),
  .cursor_zoom_factor_ff(cursor_zoom_factor_ff), .input_swing_min_ff(input_swing_min_ff),
  .input_swing_max_ff(input_swing_max_ff), .horizontal_interp_en_ff(horizontal_interp_en_ff));

// ### tb/eocr_regs_bench.sv
// Self-checking bench for the encoder output config bank
`timescale 1ns/1ps
`include "eocr_cfg.svh"
module eocr_regs_bench
  import eocr_pkg::*;
;
  logic          mclk, srst, cg_runin_done, cg_bit_tick, teletext_request, half_crystal_clk;
  eocr_bus_req_t bus_req;
  logic [7:0]    rd_data_ff, input_swing_min_ff, input_swing_max_ff, p;
  logic          pin_ff, encoder_bypass_ff, copy_gen_active_ff, copy_gen_bit_ff, copy_gen_bit_valid_ff;
  logic          vertical_upscale_en_ff, horizontal_interp_en_ff;
  logic [1:0]    cursor_zoom_factor_ff;
  eocr_dac_src_t green_dac_src_ff, blue_dac_src_ff, red_dac_src_ff;
  eocr_vfil_t    vertical_filter_place_ff;
  int            err_count, n_tests;
  logic [19:0]   pay = 20'h93CA5;
  logic [7:0]    ra [6] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h37, 8'h2E};
  logic [7:0]    rv [6] = '{8'h00, 8'h00, 8'h00, 8'hB4, 8'h00, 8'h00};
  logic [7:0]    pv [9] = '{8'h00, 8'h80, 8'hC0, 8'h20, 8'h10, 8'h12, 8'h02, 8'hB8, 8'hFA};
  logic [7:0]    sv [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h50, 8'h07, 8'h46};
  logic [7:0]    ds [2] = '{8'h00, 8'h04};

  eocr_regs u_eocr_regs (.mclk(mclk), .srst(srst), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
    .cg_runin_done(cg_runin_done), .cg_bit_tick(cg_bit_tick), .teletext_request(teletext_request),
    .half_crystal_clk(half_crystal_clk), .teletext_req_or_clock_pin_ff(pin_ff),
    .green_dac_src_ff(green_dac_src_ff), .blue_dac_src_ff(blue_dac_src_ff), .red_dac_src_ff(red_dac_src_ff),
    .encoder_bypass_ff(encoder_bypass_ff), .copy_gen_active_ff(copy_gen_active_ff),
    .copy_gen_bit_ff(copy_gen_bit_ff), .copy_gen_bit_valid_ff(copy_gen_bit_valid_ff),
    .vertical_upscale_en_ff(vertical_upscale_en_ff), .vertical_filter_place_ff(vertical_filter_place_ff),
    .cursor_zoom_factor_ff(cursor_zoom_factor_ff), .input_swing_min_ff(input_swing_min_ff),
    .input_swing_max_ff(input_swing_max_ff), .horizontal_interp_en_ff(horizontal_interp_en_ff));

  // Compare one value, four-state exact
  task automatic chk_val(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 chk_val(rd_data_ff, exp);
  endtask
  // Let the decoded outputs catch up with a write
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic runin();
    @(posedge mclk);
    cg_runin_done <= 1'b1;
    @(posedge mclk);
    cg_runin_done <= 1'b0;
  endtask
  // One bit period; checks the marker and the bit that follow it
  task automatic tick(logic v, logic b);
    @(posedge mclk);
    cg_bit_tick <= 1'b1;
    @(posedge mclk);
    cg_bit_tick <= 1'b0;
    #1 chk_val({7'h00, copy_gen_bit_valid_ff}, {7'h00, v});
    if (v) chk_val({7'h00, copy_gen_bit_ff}, {7'h00, b});
  endtask
  task automatic defaults();
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
  endtask
  task automatic end_test(string s);
    $display("Test %s finished, mismatches so far %0d", s, err_count);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Hang guard, far beyond the expected run length
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    {srst, cg_runin_done, cg_bit_tick, teletext_request, half_crystal_clk} = 5'h10;
    bus_req = '0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    wr(8'h2E, 8'h5A);
    defaults();
    end_test("defaults");
    foreach (pv[i]) begin
      p = pv[i];
      wr(`EOCR_ADDR_PIN_SEL, p);
      rd_chk(`EOCR_ADDR_PIN_SEL, p);
      settle();
      chk_val(8'(green_dac_src_ff), 8'(p[3] ? EOCR_DAC_RGB_BYPASS : p[6] ? EOCR_DAC_COMPOSITE :
        p[7] ? EOCR_DAC_LUMA : EOCR_DAC_COMPONENT));
      chk_val(8'(blue_dac_src_ff), 8'(p[3] ? EOCR_DAC_RGB_BYPASS : p[5] ? EOCR_DAC_COMPOSITE :
        EOCR_DAC_COMPONENT));
      chk_val(8'(red_dac_src_ff), 8'(p[3] ? EOCR_DAC_RGB_BYPASS : p[1] ? EOCR_DAC_COMPOSITE :
        p[4] ? EOCR_DAC_CHROMA : EOCR_DAC_COMPONENT));
      chk_val({7'h00, encoder_bypass_ff}, {7'h00, p[3]});
    end
    end_test("pin sources");
    foreach (ds[j]) begin
      wr(`EOCR_ADDR_PIN_SEL, ds[j]);
      for (int k = 0; k < 2; k++) begin
        @(posedge mclk);
        teletext_request <= k[0];
        half_crystal_clk <= ~k[0];
        repeat (5) @(posedge mclk);
        #1 chk_val({7'h00, pin_ff}, {7'h00, ds[j][2] ^ k[0]});
      end
    end
    end_test("dual pin");
    foreach (sv[i]) begin
      p = sv[i];
      wr(`EOCR_ADDR_SCALER, p);
      rd_chk(`EOCR_ADDR_SCALER, p);
      settle();
      chk_val(8'(vertical_filter_place_ff),
        8'((p[6] || p[5:4] == 2'h3) ? EOCR_VFIL_NONE : eocr_vfil_t'(p[5:4])));
      chk_val({7'h00, vertical_upscale_en_ff}, {7'h00, p[6]});
      chk_val({6'h00, cursor_zoom_factor_ff}, p[2] ? 8'h02 : 8'h01);
      chk_val(input_swing_min_ff, p[1] ? 8'h00 : 8'h10);
      chk_val(input_swing_max_ff, p[1] ? 8'hFF : 8'hEB);
      chk_val({7'h00, horizontal_interp_en_ff}, {7'h00, p[0]});
    end
    end_test("scaler");
    wr(`EOCR_ADDR_CG_LOW, pay[7:0]);
    wr(`EOCR_ADDR_CG_MID, pay[15:8]);
    wr(`EOCR_ADDR_CG_HIGH, {4'h8, pay[19:16]});
    settle();
    chk_val({7'h00, copy_gen_active_ff}, 8'h01);
    runin();
    for (int i = 0; i < 20; i++) tick(1'b1, pay[i]);
    tick(1'b0, 1'b0);
    wr(`EOCR_ADDR_CG_HIGH, {4'h0, pay[19:16]});
    settle();
    chk_val({7'h00, copy_gen_active_ff}, 8'h00);
    runin();
    tick(1'b0, 1'b0);
    end_test("copy generation");
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    defaults();
    end_test("second reset");
    complete_run();
  end
endmodule
